/* design/rms_ctl.sv */
`timescale 1ns/100ps
module rms_ctl #(
  parameter int unsigned WAKE_CYC   = rms_pkg::WAKE_CYC,
  parameter int unsigned TX_MAX_CYC = rms_pkg::TX_MAX_CYC
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [4:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [4:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  rms_link_if.host          link
);

  typedef struct packed {
    logic                 aw_v;
    logic [4:0]           aw_a;
    logic                 w_v;
    logic [31:0]          w_d;
    logic                 w_s;
    logic                 awr;
    logic                 wr;
    logic                 bv;
    logic [1:0]           br;
    logic                 arr;
    logic                 rv;
    logic [31:0]          rd;
    logic [1:0]           rr;
    logic [7:0]           ctrl;
    logic                 cfg_ok;
    logic [31:0]          wake;
    logic                 ce;
    logic                 hold;
    logic                 pulse_pend;
    logic [31:0]          ce_cnt;
    logic [31:0]          ce_on;
    logic                 csn;
    logic                 cfg_we;
    logic                 tx_we;
    logic [31:0]          tx_d;
    logic                 txp;
    logic                 rx_re;
    rms_pkg::rms_hstate_t hs;
  } rms_host_t;

  rms_host_t s_r;
  rms_host_t s_nxt;
  logic      can_ce;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cfg_we = 1'b0;
    s_nxt.tx_we = 1'b0;
    s_nxt.rx_re = 1'b0;
    if (s_r.awr && awvalid) begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = awaddr;
    end
    if (s_r.wr && wvalid) begin
      s_nxt.w_v = 1'b1;
      s_nxt.w_d = wdata;
      s_nxt.w_s = wstrb[0];
    end
    if (s_r.bv && bready) begin
      s_nxt.bv = 1'b0;
    end
    if (s_r.aw_v && s_r.w_v && !s_r.bv && s_r.hs == rms_pkg::RMS_H_IDLE) begin
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v = 1'b0;
      s_nxt.bv = 1'b1;
      s_nxt.br = rms_pkg::RESP_OKAY;
      if (s_r.aw_a == rms_pkg::A_CTRL) begin
        if (s_r.w_s) begin
          s_nxt.ctrl = s_r.w_d[7:0];
          s_nxt.cfg_we = 1'b1;
          s_nxt.cfg_ok = 1'b1;
          if (s_r.w_d[rms_pkg::CFG_POWER_UP_BIT] && !s_r.ctrl[rms_pkg::CFG_POWER_UP_BIT]) begin
            s_nxt.wake = WAKE_CYC;
          end
        end
      end else if (s_r.aw_a == rms_pkg::A_CMD) begin
        s_nxt.pulse_pend = s_r.pulse_pend | s_r.w_d[rms_pkg::CMD_PULSE];
        s_nxt.hold = s_r.w_d[rms_pkg::CMD_HOLD];
      end else if (s_r.aw_a == rms_pkg::A_TXD) begin
        s_nxt.tx_d = s_r.w_d;
        s_nxt.txp = 1'b1;
      end else begin
        s_nxt.br = rms_pkg::RESP_SLVERR;
      end
    end
    s_nxt.awr = !s_nxt.aw_v;
    s_nxt.wr = !s_nxt.w_v;

    if (s_r.rv && rready) begin
      s_nxt.rv = 1'b0;
    end
    if (s_r.arr && arvalid) begin
      s_nxt.rv = 1'b1;
      s_nxt.rd = '0;
      s_nxt.rr = rms_pkg::RESP_OKAY;
      if (araddr == rms_pkg::A_CTRL) begin
        s_nxt.rd[7:0] = s_r.ctrl;
      end else if (araddr == rms_pkg::A_CMD) begin
        s_nxt.rd[rms_pkg::CMD_HOLD] = s_r.hold;
        s_nxt.rd[rms_pkg::CMD_PULSE] = s_r.pulse_pend;
      end else if (araddr == rms_pkg::A_RXD) begin
        s_nxt.rd = link.rx_rdata;
        s_nxt.rx_re = (link.rx_count != 2'h0);
      end else if (araddr == rms_pkg::A_STAT) begin
        s_nxt.rd[rms_pkg::ST_MODE_LO +: 3] = link.mode;
        s_nxt.rd[rms_pkg::ST_TXN_LO +: 2] = link.tx_count;
        s_nxt.rd[rms_pkg::ST_RXN_LO +: 2] = link.rx_count;
        s_nxt.rd[rms_pkg::ST_RPD] = link.received_power_flag;
        s_nxt.rd[rms_pkg::ST_WAKE] = (s_r.wake != 32'h0);
        s_nxt.rd[rms_pkg::ST_BUSY] = s_r.txp;
        s_nxt.rd[rms_pkg::ST_CE] = s_r.ce;
      end else begin
        s_nxt.rr = rms_pkg::RESP_SLVERR;
      end
    end
    s_nxt.arr = !s_nxt.rv;

    if (s_r.wake != 32'h0) begin
      s_nxt.wake = s_r.wake - 32'h1;
    end
    can_ce = s_r.cfg_ok && s_r.wake == 32'h0 && s_r.ctrl[rms_pkg::CFG_POWER_UP_BIT];
    if (s_r.ce_cnt != 32'h0) begin
      s_nxt.ce_cnt = s_r.ce_cnt - 32'h1;
    end else if (s_r.pulse_pend && can_ce) begin
      s_nxt.pulse_pend = 1'b0;
      s_nxt.ce_cnt = rms_pkg::CE_PULSE_CYC;
    end
    if (s_r.hold && !s_r.ctrl[rms_pkg::CFG_PRIMARY_RECEIVE_SELECT] && s_r.ce_on == TX_MAX_CYC - 1) begin
      s_nxt.hold = 1'b0;
    end
    s_nxt.ce = can_ce && (s_nxt.ce_cnt != 32'h0 || s_nxt.hold);
    s_nxt.ce_on = s_r.ce ? s_r.ce_on + 32'h1 : 32'h0;

    case (s_r.hs)
      rms_pkg::RMS_H_IDLE: begin
        // The next enable value keeps select from falling in the cycle that enable rises.
        if (s_r.txp && (!s_nxt.ce || s_r.ce_on >= rms_pkg::CSN_CYC)) begin
          s_nxt.csn = 1'b0;
          s_nxt.tx_we = 1'b1;
          s_nxt.hs = rms_pkg::RMS_H_SEL;
        end
      end
      rms_pkg::RMS_H_SEL: begin
        s_nxt.hs = rms_pkg::RMS_H_END;
      end
      default: begin
        s_nxt.csn = 1'b1;
        s_nxt.txp = 1'b0;
        s_nxt.hs = rms_pkg::RMS_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.awr <= 1'b1;
      s_r.wr <= 1'b1;
      s_r.arr <= 1'b1;
      s_r.csn <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awr;
  assign wready = s_r.wr;
  assign bvalid = s_r.bv;
  assign bresp = s_r.br;
  assign arready = s_r.arr;
  assign rvalid = s_r.rv;
  assign rdata = s_r.rd;
  assign rresp = s_r.rr;
  assign link.ce = s_r.ce;
  assign link.csn = s_r.csn;
  assign link.cfg_we = s_r.cfg_we;
  assign link.cfg_wdata = s_r.ctrl;
  assign link.tx_we = s_r.tx_we;
  assign link.tx_wdata = s_r.tx_d;
  assign link.rx_re = s_r.rx_re;

endmodule // rms_ctl

/* design/rms_link_if.sv */
`timescale 1ns/100ps
interface rms_link_if;
  logic                ce;
  logic                csn;
  logic                cfg_we;
  logic [7:0]          cfg_wdata;
  logic                tx_we;
  logic [31:0]         tx_wdata;
  logic                rx_re;
  logic [31:0]         rx_rdata;
  logic [1:0]          rx_count;
  logic [1:0]          tx_count;
  rms_pkg::rms_mode_t  mode;
  logic                received_power_flag;

  modport dev (input ce, csn, cfg_we, cfg_wdata, tx_we, tx_wdata, rx_re,
               output rx_rdata, rx_count, tx_count, mode, received_power_flag);
  modport host (output ce, csn, cfg_we, cfg_wdata, tx_we, tx_wdata, rx_re,
                input rx_rdata, rx_count, tx_count, mode, received_power_flag);
endinterface

/* design/rms_pkg.sv */
package rms_pkg;

  typedef enum logic [2:0] {
    RMS_POR,
    RMS_PDOWN,
    RMS_STBY1,
    RMS_STBY2,
    RMS_SETTLE,
    RMS_TX,
    RMS_RX
  } rms_mode_t;

  typedef enum logic [1:0] {
    RMS_H_IDLE,
    RMS_H_SEL,
    RMS_H_END
  } rms_hstate_t;

  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned T_POR_US     = 1000;
  localparam int unsigned T_SETTLE_US  = 130;
  localparam int unsigned T_RPD_US     = 40;
  localparam int unsigned T_CE_MIN_US  = 10;
  localparam int unsigned T_CSN_US     = 4;
  localparam int unsigned T_WAKE_US    = 1500;
  localparam int unsigned T_TX_MAX_US  = 4000;
  localparam int unsigned T_PKT_US     = 40;

  localparam int unsigned POR_CYC      = T_POR_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC   = T_SETTLE_US * CLK_MHZ;
  localparam int unsigned RPD_CYC      = T_RPD_US * CLK_MHZ;
  localparam int unsigned CE_MIN_CYC   = T_CE_MIN_US * CLK_MHZ;
  localparam int unsigned CE_PULSE_CYC = CE_MIN_CYC + 1;
  localparam int unsigned CSN_CYC      = T_CSN_US * CLK_MHZ;
  localparam int unsigned WAKE_CYC     = T_WAKE_US * CLK_MHZ;
  localparam int unsigned TX_MAX_CYC   = T_TX_MAX_US * CLK_MHZ;
  localparam int unsigned PKT_CYC      = T_PKT_US * CLK_MHZ;

  localparam logic [1:0] TX_DEPTH = 2'h3;
  localparam logic [1:0] RX_DEPTH = 2'h3;

  localparam int unsigned CFG_POWER_UP_BIT  = 0;
  localparam int unsigned CFG_PRIMARY_RECEIVE_SELECT = 1;
  localparam int unsigned CFG_AUTO    = 2;
  localparam int unsigned CFG_RATE_LO = 3;

  localparam logic [1:0] RATE_1M   = 2'h0;
  localparam logic [1:0] RATE_2M   = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;

  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_CMD  = 5'h04;
  localparam logic [4:0] A_TXD  = 5'h08;
  localparam logic [4:0] A_RXD  = 5'h0c;
  localparam logic [4:0] A_STAT = 5'h10;

  localparam int unsigned CMD_PULSE = 0;
  localparam int unsigned CMD_HOLD  = 1;

  localparam int unsigned ST_MODE_LO = 0;
  localparam int unsigned ST_TXN_LO  = 3;
  localparam int unsigned ST_RXN_LO  = 5;
  localparam int unsigned ST_RPD     = 7;
  localparam int unsigned ST_WAKE    = 8;
  localparam int unsigned ST_BUSY    = 9;
  localparam int unsigned ST_CE      = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* design/rms_radio.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Hold reset after supply, then power down.
// - Power down keeps registers, interface stays usable.
// - Power-up bit low forces power down.
// - Power-up bit high enters standby-I.
// - Active only with chip enable high.
// - Transmitter with empty FIFO idles in standby-II.
// - Upload in standby-II starts settling at once.
// - Packet commits when chip select returns high.
// - Receive needs power-up, receive-select, chip enable.
// - Valid packet stored; dropped when FIFO full.
// - Receive holds until host changes mode.
// - Power flag after filtered 40us detection.
// - Transmit needs payload and long enable pulse.
// - After packet: standby-I, next, or standby-II.
// - Continuous transmit never exceeds 4ms. The radio ends transmit at TX_MAX_CYC only with the auto bit set.
// - Held enable drains FIFO while refilled.
// - Single enable pulse sends exactly one packet.
// - Mode entry settles within 130us.
// - Pass standby; host waits wake time.
// - Host waits 4us from enable to select.
// - Air rate chosen by rate field.
// - Host reprograms configuration after power loss.
module rms_radio #(
  parameter int unsigned POR_CYC    = rms_pkg::POR_CYC,
  parameter int unsigned SETTLE_CYC = rms_pkg::SETTLE_CYC,
  parameter int unsigned RPD_CYC    = rms_pkg::RPD_CYC,
  parameter int unsigned TX_MAX_CYC = rms_pkg::TX_MAX_CYC,
  parameter int unsigned PKT_CYC    = rms_pkg::PKT_CYC
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  rms_link_if.dev                 link,
  input  wire logic               rf_power_detect,
  input  wire logic               rx_pkt_strobe,
  input  wire logic [31:0]        rx_pkt_data,
  output logic                    air_tx_active,
  output logic [31:0]             air_tx_data,
  output logic [1:0]              air_rate,
  output rms_pkg::rms_mode_t      mode
);

  typedef struct packed {
    rms_pkg::rms_mode_t st;
    logic [31:0]        cnt;
    logic [31:0]        txon;
    logic [31:0]        ce_hi;
    logic [31:0]        rpd_cnt;
    logic               received_power_flag;
    logic               ce_s1;
    logic               ce_s2;
    logic               csn_s1;
    logic               csn_s2;
    logic               csn_q;
    logic               rfp_s1;
    logic               rfp_s2;
    logic               power_up_bit;
    logic               primary_receive_select;
    logic               auto_en;
    logic [1:0]         rate;
    logic               rx_sel;
    logic [31:0]        stage;
    logic               stage_v;
    logic [2:0][31:0]   txf;
    logic [1:0]         txn;
    logic [2:0][31:0]   rxf;
    logic [1:0]         rxn;
    logic               air_on;
    logic [31:0]        air_d;
  } rms_dev_t;

  rms_dev_t s_r;
  rms_dev_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 32'h1;
    s_nxt.ce_s1 = link.ce;
    s_nxt.ce_s2 = s_r.ce_s1;
    s_nxt.csn_s1 = link.csn;
    s_nxt.csn_s2 = s_r.csn_s1;
    s_nxt.csn_q = s_r.csn_s2;
    s_nxt.rfp_s1 = rf_power_detect;
    s_nxt.rfp_s2 = s_r.rfp_s1;

    // Configuration and data transfers are taken in every mode, power down included.
    if (link.cfg_we) begin
      s_nxt.power_up_bit = link.cfg_wdata[rms_pkg::CFG_POWER_UP_BIT];
      s_nxt.primary_receive_select = link.cfg_wdata[rms_pkg::CFG_PRIMARY_RECEIVE_SELECT];
      s_nxt.auto_en = link.cfg_wdata[rms_pkg::CFG_AUTO];
      s_nxt.rate = link.cfg_wdata[rms_pkg::CFG_RATE_LO +: 2];
    end
    if (link.tx_we) begin
      s_nxt.stage = link.tx_wdata;
      s_nxt.stage_v = 1'b1;
    end
    if (link.rx_re && s_r.rxn != 2'h0) begin
      s_nxt.rxf[0] = s_r.rxf[1];
      s_nxt.rxf[1] = s_r.rxf[2];
      s_nxt.rxf[2] = '0;
      s_nxt.rxn = s_r.rxn - 2'h1;
    end

    // The enable pulse length is remembered across settling so a pulse of CE_MIN_CYC cycles still counts after enable falls.
    if (s_r.ce_s2) begin
      if (s_r.ce_hi != rms_pkg::CE_MIN_CYC) begin
        s_nxt.ce_hi = s_r.ce_hi + 32'h1;
      end
    end else if (s_r.st != rms_pkg::RMS_SETTLE) begin
      s_nxt.ce_hi = '0;
    end

    case (s_r.st)
      rms_pkg::RMS_POR: begin
        if (s_r.cnt == POR_CYC - 1) begin
          s_nxt.st = rms_pkg::RMS_PDOWN;
        end
      end
      rms_pkg::RMS_PDOWN: begin
        if (s_r.power_up_bit) begin
          s_nxt.st = rms_pkg::RMS_STBY1;
        end
      end
      rms_pkg::RMS_STBY1: begin
        if (s_r.ce_s2 && (s_r.primary_receive_select || s_r.txn != 2'h0)) begin
          s_nxt.st = rms_pkg::RMS_SETTLE;
          s_nxt.cnt = '0;
          s_nxt.rx_sel = s_r.primary_receive_select;
        end
      end
      rms_pkg::RMS_STBY2: begin
        if (!s_r.ce_s2) begin
          s_nxt.st = rms_pkg::RMS_STBY1;
        end else if (s_r.txn != 2'h0) begin
          s_nxt.st = rms_pkg::RMS_SETTLE;
          s_nxt.cnt = '0;
          s_nxt.rx_sel = 1'b0;
        end
      end
      rms_pkg::RMS_SETTLE: begin
        if (s_r.cnt == SETTLE_CYC - 1) begin
          s_nxt.cnt = '0;
          s_nxt.txon = '0;
          if (s_r.rx_sel) begin
            s_nxt.st = s_r.ce_s2 ? rms_pkg::RMS_RX : rms_pkg::RMS_STBY1;
          end else if ((s_r.ce_s2 || s_r.ce_hi == rms_pkg::CE_MIN_CYC) && s_r.txn != 2'h0) begin
            s_nxt.st = rms_pkg::RMS_TX;
            s_nxt.air_on = 1'b1;
            s_nxt.air_d = s_r.txf[0];
          end else begin
            s_nxt.st = rms_pkg::RMS_STBY1;
          end
        end
      end
      rms_pkg::RMS_TX: begin
        s_nxt.txon = s_r.txon + 32'h1;
        if (s_r.auto_en && s_r.txon == TX_MAX_CYC - 1) begin
          s_nxt.st = rms_pkg::RMS_STBY1;
          s_nxt.air_on = 1'b0;
        end else if (s_r.cnt == PKT_CYC - 1) begin
          s_nxt.cnt = '0;
          s_nxt.txf[0] = s_r.txf[1];
          s_nxt.txf[1] = s_r.txf[2];
          s_nxt.txf[2] = '0;
          s_nxt.txn = s_r.txn - 2'h1;
          if (!s_r.ce_s2) begin
            s_nxt.st = rms_pkg::RMS_STBY1;
            s_nxt.air_on = 1'b0;
          end else if (s_r.txn > 2'h1) begin
            s_nxt.air_d = s_r.txf[1];
          end else begin
            s_nxt.st = rms_pkg::RMS_STBY2;
            s_nxt.air_on = 1'b0;
          end
        end
      end
      rms_pkg::RMS_RX: begin
        if (!s_r.ce_s2) begin
          s_nxt.st = rms_pkg::RMS_STBY1;
        end else if (!s_r.primary_receive_select) begin
          s_nxt.st = rms_pkg::RMS_SETTLE;
          s_nxt.cnt = '0;
          s_nxt.rx_sel = 1'b0;
        end
        if (rx_pkt_strobe && s_nxt.rxn != rms_pkg::RX_DEPTH) begin
          s_nxt.rxf[s_nxt.rxn] = rx_pkt_data;
          s_nxt.rxn = s_nxt.rxn + 2'h1;
        end
      end
      default: begin
        s_nxt.st = rms_pkg::RMS_POR;
      end
    endcase

    // A commit after the pop above still sees the freed slot.
    // A word staged in this very cycle stays pending for the next select frame.
    if (s_r.stage_v && s_r.csn_s2 && !s_r.csn_q) begin
      s_nxt.stage_v = link.tx_we;
      if (s_nxt.txn != rms_pkg::TX_DEPTH) begin
        s_nxt.txf[s_nxt.txn] = s_r.stage;
        s_nxt.txn = s_nxt.txn + 2'h1;
      end
    end

    // The flag follows the filtered detector in receive and is held elsewhere.
    if (s_r.st == rms_pkg::RMS_RX) begin
      if (!s_r.rfp_s2) begin
        s_nxt.rpd_cnt = '0;
        s_nxt.received_power_flag = 1'b0;
      end else if (s_r.rpd_cnt == RPD_CYC - 1) begin
        s_nxt.received_power_flag = 1'b1;
      end else begin
        s_nxt.rpd_cnt = s_r.rpd_cnt + 32'h1;
      end
    end else begin
      s_nxt.rpd_cnt = '0;
    end

    if (!s_r.power_up_bit && s_r.st != rms_pkg::RMS_POR) begin
      s_nxt.st = rms_pkg::RMS_PDOWN;
      s_nxt.air_on = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.csn_s1 <= 1'b1;
      s_r.csn_s2 <= 1'b1;
      s_r.csn_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.rx_rdata = s_r.rxf[0];
  assign link.rx_count = s_r.rxn;
  assign link.tx_count = s_r.txn;
  assign link.mode = s_r.st;
  assign link.received_power_flag = s_r.received_power_flag;
  assign air_tx_active = s_r.air_on;
  assign air_tx_data = s_r.air_d;
  assign air_rate = s_r.rate;
  assign mode = s_r.st;

endmodule // rms_radio

/* verification/rms_monitor.sv */
`timescale 1ns/100ps
module rms_monitor #(
  parameter int unsigned SETTLE_CYC = 40,
  parameter int unsigned RPD_CYC    = 10
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  input wire logic               csn,
  input wire logic               cfg_we,
  input wire logic [7:0]         cfg_wdata,
  input wire logic               tx_we,
  input wire logic [1:0]         tx_count,
  input wire rms_pkg::rms_mode_t mode,
  input wire logic               received_power_flag
);
  default clocking mcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] settle_cnt;
  logic [15:0] rx_cnt;

  // Run lengths of the settling and receive states.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 16'h0;
      rx_cnt     <= 16'h0;
    end else begin
      settle_cnt <= (mode == rms_pkg::RMS_SETTLE) ? settle_cnt + 16'h1 : 16'h0;
      rx_cnt     <= (mode == rms_pkg::RMS_RX) ? rx_cnt + 16'h1 : 16'h0;
    end
  end

  sequence ce_low3;
    !ce [*3];
  endsequence
  sequence upload_frame;
    tx_we && !csn ##1 !csn ##1 csn;
  endsequence

  a_por_exit: assert property ($fell(mode == rms_pkg::RMS_POR) |-> mode == rms_pkg::RMS_PDOWN)
    else $error("reset state left for wrong mode");
  a_pdown_forced: assert property (cfg_we && !cfg_wdata[0] && mode != rms_pkg::RMS_POR
    |-> ##[1:3] mode == rms_pkg::RMS_PDOWN) else $error("power down not entered");
  a_stby1_hold: assert property (ce_low3 ##0 mode == rms_pkg::RMS_STBY1
    |=> mode != rms_pkg::RMS_SETTLE) else $error("left standby without enable");
  a_rx_ce_low: assert property (!ce [*6] |-> mode != rms_pkg::RMS_RX)
    else $error("receive kept with enable low");
  a_tx_needs_data: assert property ($rose(mode == rms_pkg::RMS_TX) |-> tx_count != 2'h0)
    else $error("transmit entered with empty queue");
  a_stby2_upload: assert property (mode == rms_pkg::RMS_STBY2 && tx_count != 2'h0
    |-> ##[1:4] mode != rms_pkg::RMS_STBY2) else $error("upload did not start settling");
  a_settle_max: assert property (settle_cnt <= SETTLE_CYC + 1)
    else $error("settling too long");
  a_rpd_filter: assert property ($rose(received_power_flag) |-> rx_cnt >= RPD_CYC)
    else $error("power flag set too early");
  a_pdown_exit: assert property (mode == rms_pkg::RMS_PDOWN
    |=> mode inside {rms_pkg::RMS_PDOWN, rms_pkg::RMS_STBY1}) else $error("standby skipped");
  a_upload_frame: assert property ($fell(csn) |-> upload_frame)
    else $error("bad select frame");
  a_ce_awake: assert property ($rose(ce) |-> mode != rms_pkg::RMS_PDOWN && mode != rms_pkg::RMS_POR)
    else $error("enable raised while powered down");
endmodule // rms_monitor

/* verification/tb_radio_mode_state_machine.sv */
`timescale 1ns/100ps
module tb_radio_mode_state_machine;
  localparam int unsigned SETTLE = 40;
  localparam int unsigned RPDC   = 10;
  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid;
  logic               rf_power_detect, rx_pkt_strobe, air_tx_active, air_tx_q;
  logic [4:0]         awaddr, araddr;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, air_rate, rsp;
  logic [31:0]        wdata, rdata, rd, rx_pkt_data, air_tx_data, air_d_q;
  rms_pkg::rms_mode_t mode;
  logic [31:0]        sent[$];
  int                 n_errors = 0;
  int                 checks_done = 0;

  rms_link_if lnk ();
  rms_radio #(.POR_CYC(20), .SETTLE_CYC(SETTLE), .RPD_CYC(RPDC), .TX_MAX_CYC(100), .PKT_CYC(20)) rms_radio_inst (
    .aclk(aclk), .aresetn(aresetn), .link(lnk.dev), .rf_power_detect(rf_power_detect),
    .rx_pkt_strobe(rx_pkt_strobe), .rx_pkt_data(rx_pkt_data), .air_tx_active(air_tx_active),
    .air_tx_data(air_tx_data), .air_rate(air_rate), .mode(mode));
  rms_ctl #(.WAKE_CYC(30), .TX_MAX_CYC(5000)) rms_ctl_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(lnk.host));
  rms_monitor #(.SETTLE_CYC(SETTLE), .RPD_CYC(RPDC)) rms_monitor_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(lnk.ce), .csn(lnk.csn), .cfg_we(lnk.cfg_we), .cfg_wdata(lnk.cfg_wdata),
    .tx_we(lnk.tx_we), .tx_count(lnk.tx_count), .mode(lnk.mode), .received_power_flag(lnk.received_power_flag));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Records each word as it goes on air, back-to-back packets included if their words differ.
  always @(posedge aclk) begin
    air_tx_q <= air_tx_active;
    air_d_q  <= air_tx_data;
    if (air_tx_active === 1'b1 && (air_tx_q === 1'b0 || air_tx_data !== air_d_q)) sent.push_back(air_tx_data);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 500);
    rsp = bresp;
    bready <= 1'b0;
    check(n < 500, 1'b1);
  endtask

  task automatic rd_reg(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 500);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    check(n < 500, 1'b1);
  endtask

  task automatic wait_mode(input rms_pkg::rms_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    check(mode, m);
  endtask

  task automatic wait_txc(input logic [1:0] c);
    int n;
    n = 0;
    while (lnk.tx_count !== c && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    check(lnk.tx_count, c);
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [1:0] rates[3];
    rates = '{rms_pkg::RATE_1M, rms_pkg::RATE_2M, rms_pkg::RATE_250K};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rf_power_detect, rx_pkt_strobe, air_tx_q} = '0;
    {awaddr, araddr, wdata, rx_pkt_data} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wait_mode(rms_pkg::RMS_PDOWN);
    wr(5'h14, 32'h1);
    check(rsp, rms_pkg::RESP_SLVERR);
    rd_reg(5'h18);
    check(rsp, rms_pkg::RESP_SLVERR);
    check(rd, 32'h0);
    foreach (rates[i]) begin
      wr(rms_pkg::A_CTRL, {27'h0, rates[i], 3'h1});
      rd_reg(rms_pkg::A_STAT);
      check(air_rate, rates[i]);
      check(rd[2:0], rms_pkg::RMS_STBY1);
    end
    wr(rms_pkg::A_TXD, 32'hc0de_0001);
    wait_txc(2'h1);
    check(mode, rms_pkg::RMS_STBY1);
    wr(rms_pkg::A_CMD, 32'h1);
    wait_mode(rms_pkg::RMS_TX);
    wait_mode(rms_pkg::RMS_STBY1);
    check(sent.size(), 32'h1);
    check(lnk.tx_count, 2'h0);
    check(sent[0], 32'hc0de_0001);
    wr(rms_pkg::A_TXD, 32'hc0de_0002);
    wait_txc(2'h1);
    wr(rms_pkg::A_TXD, 32'hc0de_0003);
    wait_txc(2'h2);
    wr(rms_pkg::A_CMD, 32'h2);
    wait_mode(rms_pkg::RMS_STBY2);
    check(sent.size(), 32'h3);
    check(sent[2], 32'hc0de_0003);
    wr(rms_pkg::A_TXD, 32'hc0de_0004);
    wait_mode(rms_pkg::RMS_TX);
    wait_mode(rms_pkg::RMS_STBY2);
    check(sent[3], 32'hc0de_0004);
    wr(rms_pkg::A_CMD, 32'h0);
    wait_mode(rms_pkg::RMS_STBY1);
    wr(rms_pkg::A_CTRL, 32'h3);
    wr(rms_pkg::A_CMD, 32'h2);
    wait_mode(rms_pkg::RMS_RX);
    rf_power_detect <= 1'b1;
    repeat (RPDC + 2) @(posedge aclk);
    check(lnk.received_power_flag, 1'b0);
    repeat (RPDC + 4) @(posedge aclk);
    rd_reg(rms_pkg::A_STAT);
    check(rd[7], 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      rx_pkt_strobe <= 1'b1;
      rx_pkt_data   <= 32'hda7a_0000 + i;
    end
    @(posedge aclk);
    rx_pkt_strobe <= 1'b0;
    repeat (3) @(posedge aclk);
    check(lnk.rx_count, 2'h3);
    for (int i = 0; i < 3; i++) begin
      rd_reg(rms_pkg::A_RXD);
      check(rd, 32'hda7a_0000 + i);
    end
    check(mode, rms_pkg::RMS_RX);
    wr(rms_pkg::A_CTRL, 32'h12);
    wait_mode(rms_pkg::RMS_PDOWN);
    rd_reg(rms_pkg::A_CTRL);
    check(rd[7:0], 8'h12);
    check(air_rate, rms_pkg::RATE_250K);
    wstrb <= 4'he;
    wr(rms_pkg::A_CTRL, 32'h1);
    wstrb <= 4'hf;
    check(rsp, rms_pkg::RESP_OKAY);
    rd_reg(rms_pkg::A_CTRL);
    check(rd[7:0], 8'h12);
    check(mode, rms_pkg::RMS_PDOWN);
    report_and_stop();
  end
endmodule // tb_radio_mode_state_machine
